// >>> rtl/sps_defines.svh
/*
  Constants of the protocol sniffer: pin positions, store geometry, character filter, rates.
  Assumes inclusion by bare name from the sniffer module.
*/
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

`define SPS_CLK_HZ 25000000
`define SPS_BIT_SDA 0
`define SPS_BIT_SCL 1
`define SPS_BIT_RX 2
`define SPS_BIT_TX 3
`define SPS_BIT_SS 4
`define SPS_BIT_MOSI 5
`define SPS_BIT_MISO 6
`define SPS_BIT_SCK 7
`define SPS_PAGES 16
`define SPS_I2C_PAGE 64
`define SPS_SER_PAGE 40
`define SPS_I2C_DEPTH 1024
`define SPS_SER_DEPTH 640
`define SPS_ASCII_LF 8'h0a
`define SPS_ASCII_CR 8'h0d
`define SPS_ASCII_LO 8'h20
`define SPS_ASCII_HI 8'h7a
`define SPS_UART_MIN_BITS 5
`define SPS_BAUD0 1200
`define SPS_BAUD1 2400
`define SPS_BAUD2 4800
`define SPS_BAUD3 9600
`define SPS_BAUD4 19200
`define SPS_BAUD5 38400
`define SPS_BAUD6 57600
`define SPS_BAUD7 115200
`define SPS_I2C_MAX_HZ 400000
`define SPS_SPI_MOSI_MAX_HZ 950000
`define SPS_SPI_MISO_MAX_HZ 439000
`define SPS_SER_BITS 8
`define SPS_SER_CAP_LEN 256

`endif

// >>> rtl/sps_pkg.sv
/*
  Types of the protocol sniffer: modes, byte markers, configuration and store write carriers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sps_pkg;

  typedef enum logic [1:0] {
    SPS_PROTO_I2C = 2'h0,
    SPS_PROTO_UART = 2'h1,
    SPS_PROTO_SPI = 2'h2,
    SPS_PROTO_OFF = 2'h3
  } sps_proto_t;

  typedef enum logic [1:0] {
    SPS_BUF_NORMAL = 2'h0,
    SPS_BUF_SINGLE = 2'h1,
    SPS_BUF_CIRC = 2'h2
  } sps_bufmode_t;

  typedef enum logic [2:0] {
    SPS_TAG_NONE = 3'h0,
    SPS_TAG_RD_ACK = 3'h1,
    SPS_TAG_RD_NACK = 3'h2,
    SPS_TAG_WR_ACK = 3'h3,
    SPS_TAG_WR_NACK = 3'h4,
    SPS_TAG_DAT_ACK = 3'h5,
    SPS_TAG_DAT_NACK = 3'h6
  } sps_tag_t;

  typedef enum logic [1:0] {
    SPS_U_IDLE = 2'b00,
    SPS_U_START = 2'b01,
    SPS_U_DATA = 2'b11,
    SPS_U_STOP = 2'b10
  } sps_ust_t;

  typedef struct packed {
    sps_proto_t proto;
    sps_bufmode_t bufmode;
    logic ascii;
    logic invert;
    logic rs485;
    logic cpol;
    logic cpha;
    logic [2:0] baud_sel;
    logic [1:0] len_sel;
  } sps_cfg_t;

  typedef struct packed {
    logic vld;
    sps_tag_t tag;
    logic [7:0] data;
  } sps_wr_t;

endpackage

// >>> rtl/sps_sniffer.sv
/*
  Passive serial protocol sniffer: I2C, UART (with differential receive path) and SPI
  decoding feeding two paged capture stores, plus serial bit-group decoding to ser_data_q.
  Assumes pins and diff_rx are asynchronous, lclk is the link sampling clock and
  cfg is held steady between sniff_start pulses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sps_defines.svh"

// Function
// R1: I2C data line on input bit 0, clock line on input bit 1.
// R2: Read address byte tagged with read-acknowledge or read-not-acknowledge marker.
// R3: Write address byte tagged with distinct write-acknowledge or write-not-acknowledge marker.
// R4: Each following data byte in a frame stored with its ninth-bit acknowledge flag.
// R5: I2C store holds 16 pages of 64 bytes, 1024 bytes.
// R6: I2C decoding follows bus clocks up to at least 400 kHz.
// R7: UART receive on bit 2, transmit on bit 3, decoded independently.
// R8: UART length 5 to 8 bits, baud 1200 through 115200.
// R9: Separate receive and transmit stores, 16 pages of 40 bytes each.
// R10: Differential mode decodes receiver into transmit store, ignores input bit 3.
// R11: SPI select bit 4, MOSI bit 5, MISO bit 6, SCK bit 7.
// R12: SPI decoding begins only after a falling select edge.
// R13: SPI MOSI capture up to 950 kHz, MISO up to 439 kHz.
// R14: All four SPI clock polarity and phase combinations supported.
// R15: Separate MOSI and MISO stores of 16 pages by 40 bytes.
// R16: Normal mode: full store is erased and writing restarts at first page.
// R17: Single mode: capture halts once the store is full.
// R18: Circular mode: zero-filled start, newest at end, older bytes shift forward.
// R19: ASCII view shows only 0x0a, 0x0d and 0x20 through 0x7a.
// R20: ASCII view doubles bytes per page and halves pages, same total; code skips this in I2C mode, which keeps 16 pages of 64.
// R21: Inversion flips all eight inputs before waveform and every decoder.
// R22: Serial decoding takes 8 bits per channel between positions, MSB or LSB first.
// R23: I2C start and stop are data edges with clock high; first byte is address.
// R24: UART finds falling start edge on idle-high line, samples mid-bit.
module sps_sniffer #(
  parameter int CLK_HZ = `SPS_CLK_HZ,
  parameter int SER_CAP_LEN = `SPS_SER_CAP_LEN
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lclk,
  input wire logic [7:0] pin_in,
  input wire logic diff_rx,
  input wire sps_pkg::sps_cfg_t cfg,
  input wire logic sniff_start,
  input wire logic sniff_stop,
  input wire logic rd_sel,
  input wire logic [9:0] rd_addr,
  input wire logic ser_arm,
  input wire logic ser_cursor_en,
  input wire logic [15:0] ser_pos_a,
  input wire logic [15:0] ser_pos_b,
  input wire logic ser_msb_first,
  output logic [7:0] wave_q,
  output logic running_q,
  output logic [10:0] fill0_q,
  output logic [10:0] fill1_q,
  output logic [6:0] page_len_q,
  output logic [4:0] page_cnt_q,
  output logic [7:0] rd_data_q,
  output sps_pkg::sps_tag_t rd_tag_q,
  output logic rd_valid_q,
  output logic rd_printable_q,
  output logic [63:0] ser_data_q,
  output logic ser_done_q
);

  // Link-side and system-side synchronisers
  logic [8:0] l1_q;
  logic [8:0] l2_q;
  logic [8:0] c1_q;
  logic [8:0] c2_q;
  logic [8:0] s_q;
  logic [8:0] sp_q;
  logic [8:0] s_d;

  always_ff @(posedge lclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      l1_q <= 9'h000;
      l2_q <= 9'h000;
    end
    else
    begin
      l1_q <= {diff_rx, pin_in};
      l2_q <= l1_q;
    end
  end

  always_comb
  begin
    s_d = c2_q ^ {1'b0, {8{cfg.invert}}}; // R21
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c1_q <= 9'h000;
      c2_q <= 9'h000;
      s_q <= 9'h000;
      sp_q <= 9'h000;
    end
    else
    begin
      c1_q <= l2_q;
      c2_q <= c1_q;
      s_q <= s_d;
      sp_q <= s_q;
    end
  end

  assign wave_q = s_q[7:0];

  function automatic logic [15:0] sps_baud_div(input logic [2:0] sel);
    int b;
    case (sel)
      3'h0: b = `SPS_BAUD0;
      3'h1: b = `SPS_BAUD1;
      3'h2: b = `SPS_BAUD2;
      3'h3: b = `SPS_BAUD3;
      3'h4: b = `SPS_BAUD4;
      3'h5: b = `SPS_BAUD5;
      3'h6: b = `SPS_BAUD6;
      default: b = `SPS_BAUD7;
    endcase
    return 16'(CLK_HZ / b);
  endfunction

  function automatic logic [10:0] sps_map(input logic [9:0] a, input logic [9:0] wp,
                                          input logic [10:0] fill, input logic [10:0] dep,
                                          input logic circ);
    logic [10:0] t;
    logic v;
    t = {1'b0, wp} + {1'b0, a};
    v = ({1'b0, a} < dep) && (circ ? ({1'b0, a} >= (dep - fill)) : ({1'b0, a} < fill));
    if (!circ)
      t = {1'b0, a};
    else if (t >= dep)
      t = t - dep;
    return {v, t[9:0]};
  endfunction

  function automatic logic sps_printable(input logic [7:0] b);
    return (b == `SPS_ASCII_LF) || (b == `SPS_ASCII_CR) ||
           (b >= `SPS_ASCII_LO && b <= `SPS_ASCII_HI);
  endfunction

  // I2C decoder
  logic i_act_q, i_act_d, i_adr_q, i_adr_d;
  logic [3:0] i_cnt_q, i_cnt_d;
  logic [7:0] i_sh_q, i_sh_d;
  sps_pkg::sps_wr_t i_wr;

  always_comb
  begin
    logic sda;
    logic scl;
    sda = s_q[`SPS_BIT_SDA]; // R1
    scl = s_q[`SPS_BIT_SCL];
    i_act_d = i_act_q;
    i_adr_d = i_adr_q;
    i_cnt_d = i_cnt_q;
    i_sh_d = i_sh_q;
    i_wr = '{vld: 1'b0, tag: sps_pkg::SPS_TAG_NONE, data: i_sh_q};
    if (scl && sp_q[`SPS_BIT_SCL] && !sda && sp_q[`SPS_BIT_SDA])
    begin
      i_act_d = 1'b1; // R23
      i_adr_d = 1'b1;
      i_cnt_d = 4'h0;
    end
    else if (scl && sp_q[`SPS_BIT_SCL] && sda && !sp_q[`SPS_BIT_SDA])
    begin
      i_act_d = 1'b0; // R23
    end
    else if (i_act_q && scl && !sp_q[`SPS_BIT_SCL]) // R6
    begin
      if (i_cnt_q < 4'h8)
      begin
        i_sh_d = {i_sh_q[6:0], sda};
        i_cnt_d = i_cnt_q + 4'h1;
      end
      else
      begin
        i_wr.vld = 1'b1;
        if (i_adr_q && i_sh_q[0])
          i_wr.tag = sda ? sps_pkg::SPS_TAG_RD_NACK : sps_pkg::SPS_TAG_RD_ACK; // R2
        else if (i_adr_q)
          i_wr.tag = sda ? sps_pkg::SPS_TAG_WR_NACK : sps_pkg::SPS_TAG_WR_ACK; // R3
        else
          i_wr.tag = sda ? sps_pkg::SPS_TAG_DAT_NACK : sps_pkg::SPS_TAG_DAT_ACK; // R4
        i_cnt_d = 4'h0;
        i_adr_d = 1'b0;
      end
    end
  end

  // UART decoders, one per line
  sps_pkg::sps_ust_t u_st_q [2];
  sps_pkg::sps_ust_t u_st_d [2];
  logic [15:0] u_cnt_q [2];
  logic [15:0] u_cnt_d [2];
  logic [2:0] u_bit_q [2];
  logic [2:0] u_bit_d [2];
  logic [7:0] u_sh_q [2];
  logic [7:0] u_sh_d [2];
  logic [1:0] u_emit;

  always_comb
  begin
    logic [15:0] div;
    logic [2:0] last;
    logic ln;
    logic lp;
    div = sps_baud_div(cfg.baud_sel); // R8
    last = 3'({1'b0, cfg.len_sel} + 3'(`SPS_UART_MIN_BITS - 1)); // R8
    ln = 1'b0;
    lp = 1'b0;
    for (int c = 0; c < 2; c++)
    begin
      u_st_d[c] = u_st_q[c];
      u_cnt_d[c] = u_cnt_q[c];
      u_bit_d[c] = u_bit_q[c];
      u_sh_d[c] = u_sh_q[c];
      u_emit[c] = 1'b0;
      if (c == 0)
      begin
        ln = s_q[`SPS_BIT_RX]; // R7
        lp = sp_q[`SPS_BIT_RX];
      end
      else
      begin
        ln = cfg.rs485 ? s_q[8] : s_q[`SPS_BIT_TX]; // R10
        lp = cfg.rs485 ? sp_q[8] : sp_q[`SPS_BIT_TX];
      end
      case (u_st_q[c])
        sps_pkg::SPS_U_IDLE:
          if (lp && !ln)
          begin
            u_st_d[c] = sps_pkg::SPS_U_START; // R24
            u_cnt_d[c] = div >> 1;
          end
        sps_pkg::SPS_U_START:
          if (u_cnt_q[c] != 16'h0000)
            u_cnt_d[c] = u_cnt_q[c] - 16'h0001;
          else if (!ln)
          begin
            u_st_d[c] = sps_pkg::SPS_U_DATA;
            u_cnt_d[c] = div - 16'h0001;
            u_bit_d[c] = 3'h0;
            u_sh_d[c] = 8'h00;
          end
          else
            u_st_d[c] = sps_pkg::SPS_U_IDLE;
        sps_pkg::SPS_U_DATA:
          if (u_cnt_q[c] != 16'h0000)
            u_cnt_d[c] = u_cnt_q[c] - 16'h0001;
          else
          begin
            u_sh_d[c][u_bit_q[c]] = ln; // R24
            u_cnt_d[c] = div - 16'h0001;
            u_bit_d[c] = u_bit_q[c] + 3'h1;
            if (u_bit_q[c] == last)
              u_st_d[c] = sps_pkg::SPS_U_STOP;
          end
        sps_pkg::SPS_U_STOP:
          if (u_cnt_q[c] != 16'h0000)
            u_cnt_d[c] = u_cnt_q[c] - 16'h0001;
          else
          begin
            u_emit[c] = 1'b1;
            u_st_d[c] = sps_pkg::SPS_U_IDLE;
          end
        default:
          u_st_d[c] = sps_pkg::SPS_U_IDLE;
      endcase
    end
  end

  // SPI decoder
  logic p_arm_q, p_arm_d;
  logic [2:0] p_cnt_q, p_cnt_d;
  logic [7:0] p_mo_q, p_mo_d, p_mi_q, p_mi_d;
  logic p_emit;

  always_comb
  begin
    logic rise;
    logic fall;
    logic smp;
    rise = s_q[`SPS_BIT_SCK] && !sp_q[`SPS_BIT_SCK]; // R11
    fall = !s_q[`SPS_BIT_SCK] && sp_q[`SPS_BIT_SCK];
    smp = (cfg.cpol == cfg.cpha) ? rise : fall; // R14
    p_arm_d = p_arm_q;
    p_cnt_d = p_cnt_q;
    p_mo_d = p_mo_q;
    p_mi_d = p_mi_q;
    p_emit = 1'b0;
    if (!s_q[`SPS_BIT_SS] && sp_q[`SPS_BIT_SS])
    begin
      p_arm_d = 1'b1; // R12
      p_cnt_d = 3'h0;
    end
    else if (s_q[`SPS_BIT_SS])
      p_arm_d = 1'b0;
    else if (p_arm_q && smp) // R13
    begin
      p_mo_d = {p_mo_q[6:0], s_q[`SPS_BIT_MOSI]};
      p_mi_d = {p_mi_q[6:0], s_q[`SPS_BIT_MISO]};
      p_cnt_d = p_cnt_q + 3'h1;
      p_emit = (p_cnt_q == 3'h7);
    end
  end

  // Store write requests per channel
  sps_pkg::sps_wr_t wr [2];

  always_comb
  begin
    wr[0] = '{vld: 1'b0, tag: sps_pkg::SPS_TAG_NONE, data: 8'h00};
    wr[1] = '{vld: 1'b0, tag: sps_pkg::SPS_TAG_NONE, data: 8'h00};
    case (cfg.proto)
      sps_pkg::SPS_PROTO_I2C: wr[0] = i_wr;
      sps_pkg::SPS_PROTO_UART:
      begin
        wr[0] = '{vld: u_emit[0], tag: sps_pkg::SPS_TAG_NONE, data: u_sh_q[0]}; // R9
        wr[1] = '{vld: u_emit[1], tag: sps_pkg::SPS_TAG_NONE, data: u_sh_q[1]}; // R10
      end
      sps_pkg::SPS_PROTO_SPI:
      begin
        wr[0] = '{vld: p_emit, tag: sps_pkg::SPS_TAG_NONE, data: p_mo_d}; // R15
        wr[1] = '{vld: p_emit, tag: sps_pkg::SPS_TAG_NONE, data: p_mi_d};
      end
      default: ;
    endcase
  end

  // Store fill control
  logic [10:0] mem0 [0:`SPS_I2C_DEPTH-1];
  logic [7:0] mem1 [0:`SPS_SER_DEPTH-1];
  logic [10:0] fill_q [2];
  logic [10:0] fill_d [2];
  logic [9:0] wp_q [2];
  logic [9:0] wp_d [2];
  logic [9:0] waddr [2];
  logic [10:0] dep [2];
  logic [1:0] we;
  logic run_d;
  logic circ;

  always_comb
  begin
    circ = (cfg.bufmode == sps_pkg::SPS_BUF_CIRC);
    dep[0] = (cfg.proto == sps_pkg::SPS_PROTO_I2C) ? 11'(`SPS_I2C_DEPTH) : 11'(`SPS_SER_DEPTH); // R5
    dep[1] = 11'(`SPS_SER_DEPTH); // R9
    run_d = running_q;
    if (sniff_start)
      run_d = 1'b1;
    else if (sniff_stop)
      run_d = 1'b0;
    for (int c = 0; c < 2; c++)
    begin
      fill_d[c] = fill_q[c];
      wp_d[c] = wp_q[c];
      waddr[c] = wp_q[c];
      we[c] = !sniff_start && running_q && wr[c].vld;
      if (sniff_start)
      begin
        fill_d[c] = 11'h000; // R18
        wp_d[c] = 10'h000;
      end
      else if (we[c] && circ)
      begin
        wp_d[c] = ({1'b0, wp_q[c]} + 11'h001 == dep[c]) ? 10'h000 : wp_q[c] + 10'h001; // R18
        fill_d[c] = (fill_q[c] == dep[c]) ? fill_q[c] : fill_q[c] + 11'h001;
      end
      else if (we[c])
      begin
        waddr[c] = (fill_q[c] == dep[c]) ? 10'h000 : fill_q[c][9:0];
        fill_d[c] = (fill_q[c] == dep[c]) ? 11'h001 : fill_q[c] + 11'h001; // R16
        if (cfg.bufmode == sps_pkg::SPS_BUF_SINGLE && fill_q[c] + 11'h001 == dep[c])
          run_d = 1'b0; // R17
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (we[0])
      mem0[waddr[0]] <= {wr[0].tag, wr[0].data};
    if (we[1])
      mem1[waddr[1]] <= wr[1].data;
  end

  // Read-out and page geometry
  logic [10:0] rmap;
  logic [10:0] rword;
  logic [7:0] rd_data_d;
  sps_pkg::sps_tag_t rd_tag_d;
  logic [6:0] plen_d;
  logic [4:0] pcnt_d;

  always_comb
  begin
    logic c;
    c = rd_sel;
    rmap = sps_map(rd_addr, wp_q[c], fill_q[c], dep[c], circ); // R18
    rword = c ? {3'h0, mem1[rmap[9:0] % `SPS_SER_DEPTH]} : mem0[rmap[9:0]];
    rd_data_d = rmap[10] ? rword[7:0] : 8'h00;
    rd_tag_d = rmap[10] ? sps_pkg::sps_tag_t'(rword[10:8]) : sps_pkg::SPS_TAG_NONE;
    plen_d = (cfg.proto == sps_pkg::SPS_PROTO_I2C) ? 7'(`SPS_I2C_PAGE) : 7'(`SPS_SER_PAGE);
    pcnt_d = 5'(`SPS_PAGES);
    if (cfg.ascii && cfg.proto != sps_pkg::SPS_PROTO_I2C)
    begin
      plen_d = plen_d << 1; // R20
      pcnt_d = pcnt_d >> 1;
    end
  end

  // Serial bit-group decoding
  logic sr_on_q, sr_on_d;
  logic [15:0] sr_idx_q, sr_idx_d, sr_tgt_q, sr_tgt_d;
  logic [2:0] sr_k_q, sr_k_d;
  logic [63:0] ser_data_d;
  logic ser_done_d;

  always_comb
  begin
    logic [15:0] first;
    logic [15:0] last;
    logic [15:0] step;
    first = ser_cursor_en ? ser_pos_a : 16'h0000; // R22
    last = ser_cursor_en ? ser_pos_b : 16'(SER_CAP_LEN - 1);
    step = (last - first) / 16'(`SPS_SER_BITS);
    if (step == 16'h0000)
      step = 16'h0001;
    sr_on_d = sr_on_q;
    sr_idx_d = sr_idx_q;
    sr_tgt_d = sr_tgt_q;
    sr_k_d = sr_k_q;
    ser_data_d = ser_data_q;
    ser_done_d = ser_done_q;
    if (ser_arm)
    begin
      sr_on_d = 1'b1;
      sr_idx_d = 16'h0000;
      sr_tgt_d = first;
      sr_k_d = 3'h0;
      ser_data_d = 64'h0;
      ser_done_d = 1'b0;
    end
    else if (sr_on_q)
    begin
      sr_idx_d = sr_idx_q + 16'h0001;
      if (sr_idx_q == sr_tgt_q)
      begin
        for (int ch = 0; ch < 8; ch++)
          ser_data_d[ch*8 +: 8] = ser_msb_first ? {ser_data_q[ch*8 +: 7], s_q[ch]}
                                                : {s_q[ch], ser_data_q[ch*8+1 +: 7]}; // R22
        sr_tgt_d = sr_tgt_q + step;
        sr_k_d = sr_k_q + 3'h1;
        if (sr_k_q == 3'h7)
        begin
          sr_on_d = 1'b0;
          ser_done_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      i_act_q <= 1'b0;
      i_adr_q <= 1'b0;
      i_cnt_q <= 4'h0;
      i_sh_q <= 8'h00;
      for (int c = 0; c < 2; c++)
      begin
        u_st_q[c] <= sps_pkg::SPS_U_IDLE;
        u_cnt_q[c] <= 16'h0000;
        u_bit_q[c] <= 3'h0;
        u_sh_q[c] <= 8'h00;
        fill_q[c] <= 11'h000;
        wp_q[c] <= 10'h000;
      end
      p_arm_q <= 1'b0;
      p_cnt_q <= 3'h0;
      p_mo_q <= 8'h00;
      p_mi_q <= 8'h00;
      running_q <= 1'b0;
      rd_data_q <= 8'h00;
      rd_tag_q <= sps_pkg::SPS_TAG_NONE;
      rd_valid_q <= 1'b0;
      rd_printable_q <= 1'b0;
      page_len_q <= 7'h00;
      page_cnt_q <= 5'h00;
      sr_on_q <= 1'b0;
      sr_idx_q <= 16'h0000;
      sr_tgt_q <= 16'h0000;
      sr_k_q <= 3'h0;
      ser_data_q <= 64'h0;
      ser_done_q <= 1'b0;
    end
    else
    begin
      i_act_q <= i_act_d;
      i_adr_q <= i_adr_d;
      i_cnt_q <= i_cnt_d;
      i_sh_q <= i_sh_d;
      for (int c = 0; c < 2; c++)
      begin
        u_st_q[c] <= u_st_d[c];
        u_cnt_q[c] <= u_cnt_d[c];
        u_bit_q[c] <= u_bit_d[c];
        u_sh_q[c] <= u_sh_d[c];
        fill_q[c] <= fill_d[c];
        wp_q[c] <= wp_d[c];
      end
      p_arm_q <= p_arm_d;
      p_cnt_q <= p_cnt_d;
      p_mo_q <= p_mo_d;
      p_mi_q <= p_mi_d;
      running_q <= run_d;
      rd_data_q <= rd_data_d;
      rd_tag_q <= rd_tag_d;
      rd_valid_q <= rmap[10];
      rd_printable_q <= sps_printable(rd_data_d); // R19
      page_len_q <= plen_d;
      page_cnt_q <= pcnt_d;
      sr_on_q <= sr_on_d;
      sr_idx_q <= sr_idx_d;
      sr_tgt_q <= sr_tgt_d;
      sr_k_q <= sr_k_d;
      ser_data_q <= ser_data_d;
      ser_done_q <= ser_done_d;
    end
  end

  assign fill0_q = fill_q[0];
  assign fill1_q = fill_q[1];

endmodule

`default_nettype wire

// >>> dv/sps_sniffer_sva.sv
/*
  Sniffer checker on port timing.
  Assumes binding into sps_sniffer, clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module sps_sniffer_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire sps_pkg::sps_cfg_t cfg,
  input wire logic sniff_start,
  input wire logic ser_arm,
  input wire logic running_q,
  input wire logic [10:0] fill0_q,
  input wire logic [10:0] fill1_q,
  input wire logic [6:0] page_len_q,
  input wire logic [4:0] page_cnt_q,
  input wire logic [7:0] rd_data_q,
  input wire sps_pkg::sps_tag_t rd_tag_q,
  input wire logic rd_valid_q,
  input wire logic rd_printable_q,
  input wire logic ser_done_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_i2c_pages: assert property (
    cfg.proto == sps_pkg::SPS_PROTO_I2C && $stable(cfg)
    |=> page_len_q == 7'h40 && page_cnt_q == 5'h10) else $error("i2c page shape");
  a_ser_pages: assert property (
    cfg.proto != sps_pkg::SPS_PROTO_I2C && !cfg.ascii && $stable(cfg)
    |=> page_len_q == 7'h28 && page_cnt_q == 5'h10) else $error("serial page shape");
  a_ascii_pages: assert property (
    cfg.proto != sps_pkg::SPS_PROTO_I2C && cfg.ascii && $stable(cfg)
    |=> page_len_q == 7'h50 && page_cnt_q == 5'h08) else $error("ascii page shape");
  a_printable_set: assert property (
    rd_valid_q |-> rd_printable_q == (rd_data_q == 8'h0a || rd_data_q == 8'h0d
    || (rd_data_q >= 8'h20 && rd_data_q <= 8'h7a))) else $error("printable flag");
  a_empty_slot: assert property (
    !rd_valid_q |-> rd_data_q == 8'h00 && rd_tag_q == sps_pkg::SPS_TAG_NONE)
    else $error("empty slot");
  a_stopped_hold: assert property (
    !running_q && !sniff_start |=> $stable(fill0_q) && $stable(fill1_q))
    else $error("fill moved");
  a_fill_step: assert property (
    !sniff_start |=> fill0_q - $past(fill0_q) <= 11'h001 || fill0_q == 11'h001)
    else $error("fill jumped");
  a_start_clear: assert property (
    sniff_start |=> running_q && fill0_q == 11'h000 && fill1_q == 11'h000)
    else $error("no clear");
  a_spi_pair: assert property (
    cfg.proto == sps_pkg::SPS_PROTO_SPI && !$past(sniff_start)
    |-> $changed(fill0_q) == $changed(fill1_q)) else $error("spi stores apart");
  a_ser_done: assert property (
    ser_arm |=> !ser_done_q ##[1:300] ser_done_q) else $error("serial late");
endmodule
bind sps_sniffer sps_sniffer_sva i_sps_sniffer_sva (
  .clk(clk), .rst_n(rst_n), .cfg(cfg), .sniff_start(sniff_start), .ser_arm(ser_arm),
  .running_q(running_q), .fill0_q(fill0_q), .fill1_q(fill1_q),
  .page_len_q(page_len_q), .page_cnt_q(page_cnt_q), .rd_data_q(rd_data_q),
  .rd_tag_q(rd_tag_q), .rd_valid_q(rd_valid_q), .rd_printable_q(rd_printable_q),
  .ser_done_q(ser_done_q)
);
`default_nettype wire

// >>> dv/sps_bus_model.sv
/*
  Watched bus model.
  Assumes one task at a time, UART pair excepted.
*/
`timescale 1ns/1ps
`default_nettype none
module sps_bus_model #(
  parameter int HALF = 800,
  parameter int BIT = 640
) (
  output logic [7:0] pins,
  output logic diff_rx
);
  initial
  begin
    pins = 8'h1f;
    diff_rx = 1'b1;
  end
  task automatic set_pins(input logic [7:0] v);
    pins = v;
  endtask
  task automatic i2c_frame(input logic [23:0] b, input int n, input logic [2:0] nack);
    int i;
    int k;
    pins[1:0] = 2'b11;
    #HALF pins[0] = 1'b0;
    #HALF pins[1] = 1'b0;
    for (i = 0; i < n; i++)
    begin
      for (k = 0; k < 9; k++)
      begin
        pins[0] = (k < 8) ? b[23 - 8 * i - k] : nack[i];
        #HALF pins[1] = 1'b1;
        #HALF pins[1] = 1'b0;
      end
    end
    pins[0] = 1'b0;
    #HALF pins[1] = 1'b1;
    #HALF pins[0] = 1'b1;
    #HALF;
  endtask
  task automatic drive(input int line, input logic v);
    if (line == 8)
      diff_rx = v;
    else
      pins[line] = v;
  endtask
  task automatic uart(input int line, input logic [7:0] b, input int nb);
    int k;
    drive(line, 1'b0);
    for (k = 0; k < nb; k++)
      #BIT drive(line, b[k]);
    #BIT drive(line, 1'b1);
    #(2 * BIT);
  endtask
  task automatic spi(input logic sel, input logic cpol, input logic cpha,
                     input logic [7:0] mosi_b, input logic [7:0] miso_b);
    int k;
    pins[7] = cpol;
    #HALF pins[4] = !sel;
    for (k = 7; k >= 0; k--)
    begin
      if (!cpha)
        pins[6:5] = {miso_b[k], mosi_b[k]};
      #HALF pins[7] = !cpol;
      if (cpha)
        pins[6:5] = {miso_b[k], mosi_b[k]};
      #HALF pins[7] = cpol;
    end
    #HALF pins[4] = 1'b1;
    pins[6] = !pins[6];
    #HALF;
  endtask
endmodule
`default_nettype wire

// >>> dv/sps_sniffer_test.sv
/*
  Sniffer bench and verdict.
  Assumes a bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module sps_sniffer_test;
  logic clk;
  logic rst_n;
  logic lclk;
  logic [7:0] pins;
  logic diff_rx;
  sps_pkg::sps_cfg_t cfg;
  sps_pkg::sps_cfg_t c;
  logic sniff_start;
  logic rd_sel;
  logic [9:0] rd_addr;
  logic ser_arm;
  logic [15:0] pos_b;
  logic [7:0] wave_q;
  logic [6:0] page_len_q;
  logic [4:0] page_cnt_q;
  logic [10:0] fill0_q;
  logic [10:0] fill1_q;
  logic [7:0] rd_data_q;
  sps_pkg::sps_tag_t rd_tag_q;
  logic rd_valid_q;
  logic rd_printable_q;
  logic [63:0] ser_data_q;
  logic ser_done_q;
  int n_mismatch;
  int n_checks;
  sps_bus_model i_sps_bus_model (.pins(pins), .diff_rx(diff_rx));
  sps_sniffer #(.CLK_HZ(19200), .SER_CAP_LEN(64)) i_sps_sniffer (
    .clk(clk), .rst_n(rst_n), .lclk(lclk), .pin_in(pins), .diff_rx(diff_rx),
    .cfg(cfg), .sniff_start(sniff_start), .sniff_stop(1'b0), .rd_sel(rd_sel),
    .rd_addr(rd_addr), .ser_arm(ser_arm), .ser_cursor_en(1'b1),
    .ser_pos_a(16'h000a), .ser_pos_b(pos_b), .ser_msb_first(1'b1), .wave_q(wave_q),
    .running_q(), .fill0_q(fill0_q), .fill1_q(fill1_q), .page_len_q(page_len_q),
    .page_cnt_q(page_cnt_q), .rd_data_q(rd_data_q), .rd_tag_q(rd_tag_q),
    .rd_valid_q(rd_valid_q), .rd_printable_q(rd_printable_q),
    .ser_data_q(ser_data_q), .ser_done_q(ser_done_q)
  );
  initial
  begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  initial
  begin
    lclk = 1'b0;
    #7;
    forever #62.5 lclk = !lclk;
  end
  task end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk_val(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task go();
    @(posedge clk);
    cfg <= c;
    @(posedge clk);
    sniff_start <= 1'b1;
    @(posedge clk);
    sniff_start <= 1'b0;
  endtask
  task wait_fill(input logic [10:0] n0, input logic [10:0] n1);
    int i;
    for (i = 0; i < 4000 && !(fill0_q === n0 && fill1_q === n1); i++)
      @(posedge clk);
    if (i == 4000)
    begin
      n_mismatch++;
      $display("wrong value at %0t: fill timeout", $time);
      end_of_test();
    end
  endtask
  task rd(input logic s, input int a);
    @(posedge clk);
    rd_sel <= s;
    rd_addr <= a[9:0];
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_i2c();
    logic [7:0] d[7] = '{8'haa, 8'h07, 8'hab, 8'h05, 8'h9a, 8'haa, 8'hab};
    sps_pkg::sps_tag_t t[7] = '{sps_pkg::SPS_TAG_WR_ACK, sps_pkg::SPS_TAG_DAT_ACK,
      sps_pkg::SPS_TAG_RD_ACK, sps_pkg::SPS_TAG_DAT_ACK, sps_pkg::SPS_TAG_DAT_NACK,
      sps_pkg::SPS_TAG_WR_NACK, sps_pkg::SPS_TAG_RD_NACK};
    c = '0;
    go();
    i_sps_bus_model.i2c_frame(24'haa0700, 2, 3'b000);
    i_sps_bus_model.i2c_frame(24'hab059a, 3, 3'b100);
    i_sps_bus_model.i2c_frame(24'haa0000, 1, 3'b001);
    i_sps_bus_model.i2c_frame(24'hab0000, 1, 3'b001);
    wait_fill(11'h007, 11'h000);
    for (int i = 0; i < 7; i++)
    begin
      rd(1'b0, i);
      chk_val(rd_data_q, d[i], "i2c byte");
      chk_val(rd_tag_q, t[i], "marker");
    end
  endtask
  task t_uart();
    c = '0;
    c.proto = sps_pkg::SPS_PROTO_UART;
    for (int n = 0; n < 4; n++)
    begin
      c.len_sel = n[1:0];
      go();
      fork
        i_sps_bus_model.uart(2, 8'h41, n + 5);
        i_sps_bus_model.uart(3, 8'h7b, n + 5);
      join
      wait_fill(11'h001, 11'h001);
      rd(1'b0, 0);
      chk_val(rd_data_q, 8'h41 & (8'hff >> (3 - n)), "uart rx");
      rd(1'b1, 0);
      chk_val(rd_data_q, 8'h7b & (8'hff >> (3 - n)), "uart tx");
    end
    chk_val(rd_printable_q, 1'b0, "above printable");
    rd(1'b0, 0);
    chk_val(rd_printable_q, 1'b1, "printable");
    c.rs485 = 1'b1;
    c.ascii = 1'b1;
    go();
    fork
      i_sps_bus_model.uart(8, 8'h33, 8);
      i_sps_bus_model.uart(3, 8'h55, 8);
    join
    wait_fill(11'h000, 11'h001);
    repeat (40) @(posedge clk);
    chk_val(fill1_q, 11'h001, "diff count");
    rd(1'b1, 0);
    chk_val(rd_data_q, 8'h33, "diff byte");
    chk_val(page_len_q, 7'h50, "ascii len");
    chk_val(page_cnt_q, 5'h08, "ascii pages");
  endtask
  task t_spi();
    c = '0;
    c.proto = sps_pkg::SPS_PROTO_SPI;
    go();
    i_sps_bus_model.spi(1'b0, 1'b0, 1'b0, 8'hff, 8'hff);
    repeat (20) @(posedge clk);
    chk_val(fill0_q, 11'h000, "no select");
    for (int m = 0; m < 4; m++)
    begin
      c.cpol = m[1];
      c.cpha = m[0];
      go();
      i_sps_bus_model.spi(1'b1, m[1], m[0], 8'ha5 ^ m[7:0], 8'h3c + m[7:0]);
      wait_fill(11'h001, 11'h001);
      rd(1'b0, 0);
      chk_val(rd_data_q, 8'ha5 ^ m[7:0], "mosi");
      rd(1'b1, 0);
      chk_val(rd_data_q, 8'h3c + m[7:0], "miso");
    end
    c.bufmode = sps_pkg::SPS_BUF_CIRC;
    go();
    i_sps_bus_model.spi(1'b1, 1'b1, 1'b1, 8'h5a, 8'h00);
    wait_fill(11'h001, 11'h001);
    rd(1'b0, 639);
    chk_val(rd_data_q, 8'h5a, "newest");
    rd(1'b0, 0);
    chk_val(rd_data_q, 8'h00, "zero fill");
  endtask
  task t_inv();
    c = '0;
    c.proto = sps_pkg::SPS_PROTO_OFF;
    c.invert = 1'b1;
    go();
    i_sps_bus_model.set_pins(8'h96);
    repeat (12) @(posedge clk);
    chk_val(wave_q, 8'h69, "inverted pins");
    pos_b <= 16'h002a;
    ser_arm <= 1'b1;
    @(posedge clk);
    ser_arm <= 1'b0;
    for (int i = 0; i < 300 && ser_done_q !== 1'b1; i++)
      @(posedge clk);
    chk_val(ser_done_q, 1'b1, "serial done");
    chk_val(ser_data_q, 64'h00ffff00ff0000ff, "serial bytes");
  endtask
  initial
  begin
    rst_n = 1'b0;
    cfg = '0;
    sniff_start = 1'b0;
    rd_sel = 1'b0;
    rd_addr = 10'h000;
    ser_arm = 1'b0;
    pos_b = 16'h0000;
    n_mismatch = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_i2c();
    t_uart();
    t_spi();
    t_inv();
    end_of_test();
  end
endmodule
`default_nettype wire
